/* hires_conv_engine.sv */
// High-resolution conversion timer and divided sensor edge counter
`timescale 1ns/10ps
`default_nettype none
module hires_conv_engine (
	input  wire logic    clk,       // System clock
	input  wire logic    reset,     // Synchronous reset
	input  wire logic    ref_rise,  // Reference clock rising edge pulse
	input  wire logic    sens_rise, // Sensor clock rising edge pulse
	hires_conv_if.engine cv         // Config in, result out
);
	import hires_ind_pkg::*;

	typedef enum logic {IDLE, COUNT} eng_state_e;

	eng_state_e  state_q, state_d;
	logic [20:0] remain_q, remain_d;
	logic [20:0] limit_q, limit_d;
	logic [20:0] ticks_q, ticks_d;
	logic [2:0]  div_cnt_q, div_cnt_d;
	logic [23:0] edges_q, edges_d;
	logic [23:0] count_q, count_d;
	logic        done_q, done_d;
	logic [2:0]  div_mask;
	logic        edge_counted;

	assign cv.done  = done_q;
	assign cv.count = count_q;

	////////////////////////////////////////////////////////////////
	always_comb begin
		state_d   = state_q;
		remain_d  = remain_q;
		limit_d   = limit_q;
		ticks_d   = ticks_q;
		div_cnt_d = div_cnt_q;
		edges_d   = edges_q;
		count_d   = count_q;
		done_d    = 1'b0;
		// [RULE10] divide by 1,2,4,8
		div_mask     = 3'((4'h1 << cv.div) - 4'h1);
		edge_counted = 1'b0;
		unique case (state_q)
			IDLE: begin
				// Below the valid minimum the count would give a useless window
				if (cv.run && cv.ref_count >= REFCNT_MIN) begin
					// [RULE4] conversion length load
					limit_d   = 21'({cv.ref_count, {REFCNT_SHIFT{1'b0}}}) + CONV_EXTRA;
					remain_d  = 21'({cv.ref_count, {REFCNT_SHIFT{1'b0}}}) + CONV_EXTRA;
					ticks_d   = '0;
					div_cnt_d = '0;
					edges_d   = '0;
					state_d   = COUNT;
				end
			end
			COUNT: begin
				if (sens_rise) begin
					if (div_cnt_q == div_mask) begin
						div_cnt_d    = '0;
						edges_d      = edges_q + 24'h000001;
						edge_counted = 1'b1;
					end else begin
						div_cnt_d = div_cnt_q + 3'h1;
					end
				end
				if (!cv.run) begin
					state_d = IDLE;
				end else if (ref_rise) begin
					ticks_d = ticks_q + 21'h000001;
					// [RULE6] window ends after full count
					if (remain_q == REMAIN_LAST) begin
						count_d = edges_d;
						done_d  = 1'b1;
						state_d = IDLE;
					end else begin
						remain_d = remain_q - 21'h000001;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q   <= IDLE;
			remain_q  <= '0;
			limit_q   <= '0;
			ticks_q   <= '0;
			div_cnt_q <= '0;
			edges_q   <= '0;
			count_q   <= '0;
			done_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			remain_q  <= remain_d;
			limit_q   <= limit_d;
			ticks_q   <= ticks_d;
			div_cnt_q <= div_cnt_d;
			edges_q   <= edges_d;
			count_q   <= count_d;
			done_q    <= done_d;
		end
	end

	////////////////////////////////////////////////////////////////
	a_conv_length_exact: assert property (@(posedge clk) disable iff (reset) // [RULE4]
		done_q |-> ticks_q == limit_q)
		else $error("Conversion did not last count*16+55 reference periods");

	a_conv_load_limit: assert property (@(posedge clk) disable iff (reset) // [RULE4]
		(state_q == IDLE && state_d == COUNT) |=> limit_q == 21'($past(cv.ref_count)) * 21'h000010 + 21'h000037)
		else $error("Conversion window loaded with wrong length");

	a_longer_count_longer: assert property (@(posedge clk) disable iff (reset) // [RULE6]
		done_q |-> ticks_q > 21'($past(cv.ref_count, 1)) * 21'h000010)
		else $error("Conversion shorter than sixteen periods per count");

	a_divider_ratio: assert property (@(posedge clk) disable iff (reset) // [RULE10]
		(state_q == COUNT && sens_rise && cv.run) |=> (edges_q != $past(edges_q)) == ($past(div_cnt_q) == $past(div_mask)))
		else $error("Sensor edge counted at wrong divider phase");
endmodule : hires_conv_engine
`default_nettype wire

/* hires_conv_if.sv */
// Carrier between register logic and conversion engine
`timescale 1ns/10ps
`default_nettype none
interface hires_conv_if;
	logic [15:0] ref_count;
	logic [1:0]  div;
	logic        run;
	logic        done;
	logic [23:0] count;
	modport ctrl   (output ref_count, output div, output run, input done, input count);
	modport engine (input ref_count, input div, input run, output done, output count);
endinterface : hires_conv_if
`default_nettype wire

/* hires_ind_pkg.sv */
// Constants shared by the high-resolution inductance register block
`default_nettype none
package hires_ind_pkg;
	// Register addresses (7-bit address space)
	localparam logic [6:0] ADDR_RP_LOW      = 7'h21;
	localparam logic [6:0] ADDR_RP_HIGH     = 7'h22;
	localparam logic [6:0] ADDR_L_LOW       = 7'h23;
	localparam logic [6:0] ADDR_L_HIGH      = 7'h24;
	localparam logic [6:0] ADDR_REFCNT_LOW  = 7'h30;
	localparam logic [6:0] ADDR_REFCNT_HIGH = 7'h31;
	localparam logic [6:0] ADDR_OFFSET_LOW  = 7'h32;
	localparam logic [6:0] ADDR_OFFSET_HIGH = 7'h33;
	localparam logic [6:0] ADDR_SENSOR_CFG  = 7'h34;
	localparam logic [6:0] ADDR_HRES_LOW    = 7'h38;
	localparam logic [6:0] ADDR_HRES_MID    = 7'h39;
	localparam logic [6:0] ADDR_HRES_HIGH   = 7'h3A;

	localparam logic [7:0] REG_RESET        = 8'h00;
	localparam logic [7:0] UNMAPPED_READ    = 8'h00;

	// Serial frame: command byte (read flag, address) then one data byte
	localparam int         SPI_RW_BIT       = 7;
	localparam logic [4:0] SPI_CMD_LAST     = 5'h07;
	localparam logic [4:0] SPI_DATA_LAST    = 5'h0F;
	localparam logic [4:0] SPI_FRAME_BITS   = 5'h10;

	// Sensor divider field in the config byte
	localparam int         CFG_DIV_LSB      = 0;
	localparam int         CFG_DIV_MSB      = 1;

	// Conversion length = count * 16 + 55 reference periods
	localparam int         REFCNT_SHIFT     = 4;
	localparam logic [20:0] CONV_EXTRA      = 21'h000037;
	localparam logic [15:0] REFCNT_MIN      = 16'h0002;
	localparam logic [20:0] REMAIN_LAST     = 21'h000001;

	// Offset weight: offset sits on bits 23:8 of the result
	localparam int         OFFSET_SHIFT     = 8;
endpackage : hires_ind_pkg
`default_nettype wire

/* hires_inductance_config_regs.sv */
// Register file, serial port and result handling for high-resolution inductance
//
// What this block does, and what the host must do
// [RULE1] Host reads resistance low byte before the standard inductance high byte.
// [RULE2] Address 0x24 returns standard inductance result bits 15:8, read-only.
// [RULE3] Reference count equals 256 times byte 0x31 plus byte 0x30.
// [RULE4] Conversion lasts count times 16 plus 55 reference clock periods.
// [RULE5] Host programs the reference count between 2 and 65535.
// [RULE6] Larger count gives longer conversion, slower rate, finer result.
// [RULE7] Bytes 0x33 and 0x32 form an offset applied to every hires result.
// [RULE8] Host writes both count bytes after reset before enabling conversions.
// [RULE9] Host reads hires result bytes low, middle, then high.
// [RULE10] Divider field divides sensor frequency by 1, 2, 4 or 8.
`timescale 1ns/10ps
`default_nettype none
module hires_inductance_config_regs (
	input  wire logic        clk,                   // System clock, 20 MHz
	input  wire logic        reset,                 // Synchronous reset, active high
	input  wire logic        spi_cs_n,              // Serial chip select, active low
	input  wire logic        spi_sclk,              // Serial clock pin
	input  wire logic        spi_mosi,              // Serial data in
	output logic             spi_miso,              // Serial data out
	output logic             spi_miso_oe,           // Data out enable
	input  wire logic        reference_clock_input, // Reference clock pin
	input  wire logic        sensor_clock,          // Sensor oscillation pin
	input  wire logic        conv_enable,           // Hires conversions enabled
	input  wire logic [15:0] rp_std_result,         // Live standard resistance result
	input  wire logic [15:0] l_std_result,          // Live standard inductance result
	output logic [23:0]      hires_inductance_result, // Offset-corrected hires result
	output logic             hires_result_valid     // One-cycle new result pulse
);
	import hires_ind_pkg::*;

	hires_conv_if cv ();

	// Pin synchronisers: stage 0 read only by stage 1
	logic [1:0] sclk_s_q, cs_s_q, mosi_s_q, ref_s_q, sens_s_q;
	logic       sclk_p_q, ref_p_q, sens_p_q;
	logic       sclk_rise, sclk_fall, ref_rise, sens_rise, cs_active;

	always_ff @(posedge clk) begin
		if (reset) begin
			sclk_s_q <= '0;
			cs_s_q   <= '1;
			mosi_s_q <= '0;
			ref_s_q  <= '0;
			sens_s_q <= '0;
			sclk_p_q <= 1'b0;
			ref_p_q  <= 1'b0;
			sens_p_q <= 1'b0;
		end else begin
			sclk_s_q <= {sclk_s_q[0], spi_sclk};
			cs_s_q   <= {cs_s_q[0], spi_cs_n};
			mosi_s_q <= {mosi_s_q[0], spi_mosi};
			ref_s_q  <= {ref_s_q[0], reference_clock_input};
			sens_s_q <= {sens_s_q[0], sensor_clock};
			sclk_p_q <= sclk_s_q[1];
			ref_p_q  <= ref_s_q[1];
			sens_p_q <= sens_s_q[1];
		end
	end

	assign sclk_rise = sclk_s_q[1] & ~sclk_p_q;
	assign sclk_fall = ~sclk_s_q[1] & sclk_p_q;
	assign ref_rise  = ref_s_q[1] & ~ref_p_q;
	assign sens_rise = sens_s_q[1] & ~sens_p_q;
	assign cs_active = ~cs_s_q[1];

	////////////////////////////////////////////////////////////////
	// Serial frame and register state
	logic [4:0]  bit_cnt_q, bit_cnt_d;
	logic [7:0]  shift_q, shift_d;
	logic [7:0]  cmd_q, cmd_d;
	logic [7:0]  tx_q, tx_d;
	logic        miso_q, miso_d;
	logic        miso_oe_q, miso_oe_d;
	logic [7:0]  rcnt_lo_q, rcnt_lo_d, rcnt_hi_q, rcnt_hi_d;
	logic [7:0]  off_lo_q, off_lo_d, off_hi_q, off_hi_d;
	logic [7:0]  cfg_q, cfg_d;
	logic [15:0] rp_sh_q, rp_sh_d, l_sh_q, l_sh_d;
	logic [23:0] hres_q, hres_d, hres_sh_q, hres_sh_d;
	logic        valid_q, valid_d;
	logic [7:0]  cmd_next;
	logic [7:0]  wr_byte;

	assign cv.ref_count = {rcnt_hi_q, rcnt_lo_q};
	assign cv.div       = cfg_q[CFG_DIV_MSB:CFG_DIV_LSB];
	assign cv.run       = conv_enable;

	always_comb begin
		bit_cnt_d = bit_cnt_q;
		shift_d   = shift_q;
		cmd_d     = cmd_q;
		tx_d      = tx_q;
		miso_d    = miso_q;
		miso_oe_d = miso_oe_q;
		rcnt_lo_d = rcnt_lo_q;
		rcnt_hi_d = rcnt_hi_q;
		off_lo_d  = off_lo_q;
		off_hi_d  = off_hi_q;
		cfg_d     = cfg_q;
		rp_sh_d   = rp_sh_q;
		l_sh_d    = l_sh_q;
		hres_d    = hres_q;
		hres_sh_d = hres_sh_q;
		valid_d   = 1'b0;
		cmd_next  = {shift_q[6:0], mosi_s_q[1]};
		wr_byte   = {shift_q[6:0], mosi_s_q[1]};
		// [RULE7] offset weighted onto bits 23:8
		if (cv.done) begin
			hres_d  = cv.count - (24'({off_hi_q, off_lo_q}) << OFFSET_SHIFT);
			valid_d = 1'b1;
		end
		if (!cs_active) begin
			bit_cnt_d = '0;
			miso_oe_d = 1'b0;
		end else if (sclk_rise && bit_cnt_q < SPI_FRAME_BITS) begin
			shift_d   = cmd_next;
			bit_cnt_d = bit_cnt_q + 5'h01;
			if (bit_cnt_q == SPI_CMD_LAST) begin
				cmd_d = cmd_next;
				tx_d  = UNMAPPED_READ;
				if (cmd_next[SPI_RW_BIT]) begin
					unique case (cmd_next[6:0])
						// [RULE1] low-byte read freezes the standard set
						ADDR_RP_LOW: begin
							tx_d    = rp_std_result[7:0];
							rp_sh_d = rp_std_result;
							l_sh_d  = l_std_result;
						end
						ADDR_RP_HIGH:     tx_d = rp_sh_q[15:8];
						ADDR_L_LOW:       tx_d = l_sh_q[7:0];
						// [RULE2] frozen inductance high byte
						ADDR_L_HIGH:      tx_d = l_sh_q[15:8];
						ADDR_REFCNT_LOW:  tx_d = rcnt_lo_q;
						ADDR_REFCNT_HIGH: tx_d = rcnt_hi_q;
						ADDR_OFFSET_LOW:  tx_d = off_lo_q;
						ADDR_OFFSET_HIGH: tx_d = off_hi_q;
						ADDR_SENSOR_CFG:  tx_d = cfg_q;
						// [RULE9] low-byte read freezes the hires set
						ADDR_HRES_LOW: begin
							tx_d      = hres_q[7:0];
							hres_sh_d = hres_q;
						end
						ADDR_HRES_MID:    tx_d = hres_sh_q[15:8];
						ADDR_HRES_HIGH:   tx_d = hres_sh_q[23:16];
						default:          tx_d = UNMAPPED_READ;
					endcase
				end
			end
			if (bit_cnt_q == SPI_DATA_LAST && !cmd_q[SPI_RW_BIT]) begin
				// [RULE3] count bytes stored separately
				unique case (cmd_q[6:0])
					ADDR_REFCNT_LOW:  rcnt_lo_d = wr_byte;
					ADDR_REFCNT_HIGH: rcnt_hi_d = wr_byte;
					ADDR_OFFSET_LOW:  off_lo_d  = wr_byte;
					ADDR_OFFSET_HIGH: off_hi_d  = wr_byte;
					ADDR_SENSOR_CFG:  cfg_d     = wr_byte;
					default:          cfg_d     = cfg_q;
				endcase
			end
		end else if (sclk_fall && bit_cnt_q > SPI_CMD_LAST && bit_cnt_q < SPI_FRAME_BITS
			&& cmd_q[SPI_RW_BIT]) begin
			miso_d    = tx_q[7];
			tx_d      = {tx_q[6:0], 1'b0};
			miso_oe_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bit_cnt_q <= '0;
			shift_q   <= REG_RESET;
			cmd_q     <= REG_RESET;
			tx_q      <= REG_RESET;
			miso_q    <= 1'b0;
			miso_oe_q <= 1'b0;
			rcnt_lo_q <= REG_RESET;
			rcnt_hi_q <= REG_RESET;
			off_lo_q  <= REG_RESET;
			off_hi_q  <= REG_RESET;
			cfg_q     <= REG_RESET;
			rp_sh_q   <= '0;
			l_sh_q    <= '0;
			hres_q    <= '0;
			hres_sh_q <= '0;
			valid_q   <= 1'b0;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			shift_q   <= shift_d;
			cmd_q     <= cmd_d;
			tx_q      <= tx_d;
			miso_q    <= miso_d;
			miso_oe_q <= miso_oe_d;
			rcnt_lo_q <= rcnt_lo_d;
			rcnt_hi_q <= rcnt_hi_d;
			off_lo_q  <= off_lo_d;
			off_hi_q  <= off_hi_d;
			cfg_q     <= cfg_d;
			rp_sh_q   <= rp_sh_d;
			l_sh_q    <= l_sh_d;
			hres_q    <= hres_d;
			hres_sh_q <= hres_sh_d;
			valid_q   <= valid_d;
		end
	end

	assign spi_miso                = miso_q;
	assign spi_miso_oe             = miso_oe_q;
	assign hires_inductance_result = hres_q;
	assign hires_result_valid      = valid_q;

	hires_conv_engine u_engine (
		.clk       (clk),
		.reset     (reset),
		.ref_rise  (ref_rise),
		.sens_rise (sens_rise),
		.cv        (cv.engine)
	);

	////////////////////////////////////////////////////////////////
	a_l_high_byte: assert property (@(posedge clk) disable iff (reset) // [RULE2]
		(cs_active && sclk_rise && bit_cnt_q == 5'h07 && cmd_next == 8'hA4) |=> tx_q == l_sh_q[15:8])
		else $error("Inductance high byte not taken from frozen result");

	a_l_freeze_set: assert property (@(posedge clk) disable iff (reset) // [RULE1]
		(cs_active && sclk_rise && bit_cnt_q == 5'h07 && cmd_next == 8'hA1) |=> l_sh_q == $past(l_std_result))
		else $error("Standard result set not frozen on low byte read");

	a_count_high_write: assert property (@(posedge clk) disable iff (reset) // [RULE3]
		(cs_active && sclk_rise && bit_cnt_q == 5'h0F && cmd_q == 8'h31)
		|=> cv.ref_count[15:8] == $past(wr_byte) && cv.ref_count[7:0] == $past(rcnt_lo_q))
		else $error("Reference count high byte not placed at bits 15:8");

	a_offset_applied: assert property (@(posedge clk) disable iff (reset) // [RULE7]
		cv.done |=> hires_inductance_result == $past(cv.count) - {$past(off_hi_q), $past(off_lo_q), 8'h00}
		&& hires_result_valid)
		else $error("Hires result not corrected by offset");
endmodule : hires_inductance_config_regs
`default_nettype wire

/* spi_host_model.sv */
// Host model for the serial register port: one register per frame
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
	input  wire logic clk,     // System clock
	output logic      cs_n,    // Chip select, active low
	output logic      sclk,    // Serial clock, idles low
	output logic      mosi,    // Serial data to device
	input  wire logic miso,    // Serial data from device
	input  wire logic miso_oe  // Device drives miso
);
	// Six clk per sclk level: port needs four, miso settles within four
	localparam int HALF = 6;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command byte then data byte, MSB first; read bits taken at sclk rise
	task automatic frame(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
		logic [15:0] sh;
		sh   = {cmd, wdat};
		rdat = 8'h00;
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi <= sh[i];
			repeat (HALF) @(posedge clk);
			sclk <= 1'b1;
			// Undriven line must not pass for data
			if (i < 8)
				rdat[i] = (miso_oe === 1'b1) ? miso : 1'bx;
			repeat (HALF) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (HALF) @(posedge clk);
		cs_n <= 1'b1;
		mosi <= ~sh[0];
		repeat (HALF) @(posedge clk);
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

/* tb_hires_inductance_config_regs.sv */
// Self-checking bench for the high-resolution inductance register block
`timescale 1ns/10ps
`default_nettype none
module tb_hires_inductance_config_regs;
	import hires_ind_pkg::*;
	localparam int LIMIT = 60000;

	logic        clk                   = 1'b0;
	logic        reset                 = 1'b1;
	logic        spi_cs_n;
	logic        spi_sclk;
	logic        spi_mosi;
	logic        spi_miso;
	logic        spi_miso_oe;
	logic        reference_clock_input = 1'b0;
	logic        sensor_clock          = 1'b0;
	logic        conv_enable           = 1'b0;
	logic [15:0] rp_std_result         = 16'h0000;
	logic [15:0] l_std_result          = 16'h0000;
	logic [23:0] hires_inductance_result;
	logic        hires_result_valid;
	logic [31:0] cycles                = 32'h00000000;
	int          valid_seen            = 0;
	int          fails                 = 0;
	int          compares              = 0;
	logic [6:0]  rw_addrs [5]          = '{ADDR_REFCNT_LOW, ADDR_REFCNT_HIGH, ADDR_OFFSET_LOW,
						ADDR_OFFSET_HIGH, ADDR_SENSOR_CFG};

	initial begin
		forever #25 clk = ~clk;
	end

	hires_inductance_config_regs u_dut (.clk(clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
		.reference_clock_input(reference_clock_input), .sensor_clock(sensor_clock),
		.conv_enable(conv_enable), .rp_std_result(rp_std_result), .l_std_result(l_std_result),
		.hires_inductance_result(hires_inductance_result), .hires_result_valid(hires_result_valid));

	spi_host_model u_host (.clk(clk), .cs_n(spi_cs_n), .sclk(spi_sclk), .mosi(spi_mosi),
		.miso(spi_miso), .miso_oe(spi_miso_oe));

	////////////////////////////////////////////////////////////////////////////////
	// Reference period 4 clk, sensor period 6 clk, both within the pin speed limit
	always @(posedge clk) begin
		cycles                <= cycles + 32'h00000001;
		reference_clock_input <= cycles[1];
		sensor_clock          <= (cycles % 6) >= 3;
		if (hires_result_valid === 1'b1)
			valid_seen <= valid_seen + 1;
		if (cycles == LIMIT) begin
			fails++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	// Edge counts shift by phase of the free-running clocks, so a small tolerance
	task automatic check_near(input string what, input logic [23:0] exp, input logic [23:0] got, input int tol);
		compares++;
		if ((^got === 1'bx) || (got > exp + tol) || (got + tol < exp)) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check_near

	task automatic reg_write(input logic [6:0] addr, input logic [7:0] data);
		logic [7:0] unused;
		u_host.frame({1'b0, addr}, data, unused);
	endtask : reg_write

	task automatic reg_read(input logic [6:0] addr, output logic [7:0] data);
		u_host.frame({1'b1, addr}, 8'h00, data);
	endtask : reg_read

	function automatic logic [23:0] conv_cycles(input logic [15:0] cnt);
		return ({8'h00, cnt} * 24'h000010 + 24'h000037) * 24'h000004;
	endfunction : conv_cycles

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0]  rd;
		logic [7:0]  wd;
		logic [15:0] l_old;
		logic [15:0] rp_old;
		logic [23:0] hres;
		logic [15:0] cnt;
		logic [15:0] off;
		int          seed_val;
		int          waited;
		seed_val = $urandom(49);
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);

		foreach (rw_addrs[k]) begin
			reg_read(rw_addrs[k], rd);
			check_val("reset_value", 24'h000000, {16'h0000, rd});
		end
		$display("test reset_values done");

		// Count left at zero after reset: nothing may start
		@(posedge clk);
		conv_enable <= 1'b1;
		repeat (800) @(posedge clk);
		check_val("valid_pulses", 24'h000000, 24'(valid_seen));
		conv_enable <= 1'b0;
		$display("test count_below_min done");

		foreach (rw_addrs[k]) begin
			wd = 8'($urandom);
			reg_write(rw_addrs[k], wd);
			reg_read(rw_addrs[k], rd);
			check_val("readback", {16'h0000, wd}, {16'h0000, rd});
		end
		reg_read(7'h7F, rd);
		check_val("unmapped", {16'h0000, UNMAPPED_READ}, {16'h0000, rd});
		$display("test register_access done");

		// Mid-run reset must clear what was written
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		foreach (rw_addrs[k]) begin
			reg_read(rw_addrs[k], rd);
			check_val("mid_reset_value", 24'h000000, {16'h0000, rd});
		end
		$display("test mid_reset done");

		@(posedge clk);
		rp_std_result <= 16'($urandom);
		l_std_result  <= 16'($urandom);
		@(posedge clk);
		l_old  = l_std_result;
		rp_old = rp_std_result;
		reg_write(ADDR_L_HIGH, ~l_old[15:8]);
		reg_read(ADDR_RP_LOW, rd);
		check_val("rp_low", {16'h0000, rp_old[7:0]}, {16'h0000, rd});
		l_std_result  <= ~l_old;
		rp_std_result <= ~rp_old;
		reg_read(ADDR_L_HIGH, rd);
		check_val("l_high", {16'h0000, l_old[15:8]}, {16'h0000, rd});
		reg_read(ADDR_L_LOW, rd);
		check_val("l_low", {16'h0000, l_old[7:0]}, {16'h0000, rd});
		reg_read(ADDR_RP_HIGH, rd);
		check_val("rp_high", {16'h0000, rp_old[15:8]}, {16'h0000, rd});
		$display("test standard_result done");

		for (int i = 0; i < 5; i++) begin
			cnt = (i == 4) ? 16'h0102 : 16'($urandom_range(5, 2));
			off = 16'($urandom);
			// both count bytes, in range, before enabling
			reg_write(ADDR_REFCNT_LOW, cnt[7:0]);
			reg_write(ADDR_REFCNT_HIGH, cnt[15:8]);
			reg_write(ADDR_OFFSET_LOW, off[7:0]);
			reg_write(ADDR_OFFSET_HIGH, off[15:8]);
			reg_write(ADDR_SENSOR_CFG, {6'h00, 2'(i)});
			@(posedge clk);
			conv_enable <= 1'b1;
			waited = 0;
			while (hires_result_valid !== 1'b1 && waited < 20000) begin
				@(posedge clk);
				waited++;
			end
			check_near("conv_cycles", conv_cycles(cnt), 24'(waited), 8);
			check_near("hires_result", (conv_cycles(cnt) / 24'h000006) >> 2'(i),
				hires_inductance_result + {off, 8'h00}, 2);
			conv_enable <= 1'b0;
			// Aborted follow-on conversion must leave the result alone
			reg_read(ADDR_HRES_LOW, rd);
			hres[7:0] = rd;
			reg_read(ADDR_HRES_MID, rd);
			hres[15:8] = rd;
			reg_read(ADDR_HRES_HIGH, rd);
			hres[23:16] = rd;
			check_near("hires_bytes", (conv_cycles(cnt) / 24'h000006) >> 2'(i), hres + {off, 8'h00}, 2);
			repeat (10) @(posedge clk);
		end
		$display("test hires_conversion done");
		print_verdict();
	end
endmodule : tb_hires_inductance_config_regs
`default_nettype wire
